// *** logic/dpop_params.svh ***
`ifndef DPOP_PARAMS_SVH
`define DPOP_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DPOP_CTRL_OFFSET          12'h000
`define DPOP_STATUS_OFFSET        12'h004
`define DPOP_INT_STATUS_OFFSET    12'h008
`define DPOP_INT_MASK_OFFSET      12'h00c

// ----------------------------------------
// Control fields
// ----------------------------------------
`define DPOP_CTRL_LATCH_RISING    0
`define DPOP_CTRL_SPREAD_WIDE     1
`define DPOP_CTRL_RANGE_LO        2
`define DPOP_CTRL_RANGE_HI        3
`define DPOP_CTRL_DRIVE_EN        4
`define DPOP_CTRL_SLEEP_N         5
`define DPOP_CTRL_RESET           6'h10

// ----------------------------------------
// Status and interrupt fields
// ----------------------------------------
`define DPOP_STAT_LOCKED          0
`define DPOP_STAT_SEARCHING       1
`define DPOP_STAT_REF_LOCKING     2
`define DPOP_STAT_ACTIVITY        3
`define DPOP_STAT_PLL_RUN         4
`define DPOP_INT_LOCK_GAINED      0
`define DPOP_INT_SEARCH_TIMEOUT   1
`define DPOP_INT_ACTIVITY_LOST    2
`define DPOP_INT_RESET            3'h0

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define DPOP_REF_LOCK_CYCLES      16928
`define DPOP_SEARCH_TIMEOUT       4194304
`define DPOP_SPREAD_WAIT_CYCLES   288

`endif

// *** logic/dpop_pkg.sv ***
package dpop_pkg;

  typedef enum logic [4:0] {
    st_off       = 5'h01,
    st_ref_lock  = 5'h02,
    st_search    = 5'h04,
    st_spread    = 5'h08,
    st_locked    = 5'h10
  } dpop_lock_state_type;

  typedef struct packed {
    logic                ref_s1;
    logic                ref_s2;
    logic                ref_d;
    logic                rec_s1;
    logic                rec_s2;
    logic                rec_d;
    logic                act_s1;
    logic                act_s2;
    logic                act_d;
    logic                tw_s1;
    logic                tw_s2;
    logic [27:0]         dat_s1;
    logic [27:0]         dat_s2;
    dpop_lock_state_type lock_state;
    logic [22:0]         count;
    logic [27:0]         pend;
    logic                clk_out;
    logic                stretch;
    logic [17:0]         pixel;
    logic [8:0]          control;
    logic                phase;
    logic                lock_n;
    logic                oe_data;
    logic                oe_clock;
    logic                oe_lock;
    logic                pll_run;
    logic [5:0]          ctrl;
    logic [2:0]          int_status;
    logic [2:0]          int_mask;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic                irq;
  } dpop_regs_type;

endpackage

// *** logic/dpop_output_port.sv ***
// Function
// - The latch-edge select picks the output clock edge at which the downstream chip samples.
// - The spread select chooses 4 percent spread when high and 2 percent when low.
// - The control word outputs change only while the phase flag is low and hold otherwise.
// - The pixel word outputs change only while the phase flag is high and hold otherwise.
// - The phase flag is high when pixel words are active and low when control words are.
// - The active-low sync status marks the data outputs valid only while it is low.
// - Drive enable low floats every single-ended output except the sync status.
// - Sleep request low floats all outputs and stops the PLL; high relocks to reference then link.
// - A transition word after reference lock drops sync status and switches to the link clock.
// - No transition word within the timeout raises sync status, zeroes outputs, keeps searching.
// - A silent serial input raises sync status, zeroes the data outputs, passes the reference.
`timescale 1ns/1ps
`default_nettype none
`include "dpop_params.svh"

module dpop_output_port
  import dpop_pkg::*;
#(
  parameter int REF_LOCK_CYCLES  = `DPOP_REF_LOCK_CYCLES,
  parameter int SEARCH_TIMEOUT   = `DPOP_SEARCH_TIMEOUT,
  parameter bit HAS_SPREAD       = 1'b1
) (
  input  wire logic        pclk,                // System clock
  input  wire logic        presetn,             // Async reset, active low
  input  wire logic        psel,                // APB select
  input  wire logic        penable,             // APB access phase
  input  wire logic        pwrite,              // APB direction
  input  wire logic [11:0] paddr,               // APB byte address
  input  wire logic [31:0] pwdata,              // APB write data
  output logic      [31:0] prdata,              // APB read data
  output logic             pready,              // APB ready
  output logic             pslverr,             // APB error
  output logic             irq,                 // Level interrupt
  input  wire logic        reference_clock_in,  // Reference clock pin
  input  wire logic        recovered_clock_in,  // Link clock from decoder
  input  wire logic        link_activity,       // Serial input switching
  input  wire logic        link_transition,     // Word is a transition word
  input  wire logic        link_phase,          // Word is a video word
  input  wire logic [17:0] link_pixel,          // Decoded pixel word
  input  wire logic [8:0]  link_control,        // Decoded control word
  output logic      [17:0] pixel_word_out,      // Pixel word pins
  output logic      [8:0]  control_word_out,    // Control word pins
  output logic             video_phase_flag,    // Phase flag pin
  output logic             sync_status_n,       // Sync status, low when valid
  output logic             parallel_clock_out,  // Output clock pin
  output logic             data_oe,             // Enable: pixel, control, phase
  output logic             clock_oe,            // Enable: output clock
  output logic             sync_status_oe,      // Enable: sync status
  output logic             pll_run,             // PLL running
  output logic             spread_wide,         // Spread amount select
  output logic             range_select_hi,     // Frequency band, high bit
  output logic             range_select_lo      // Frequency band, low bit
);

  dpop_regs_type r;
  dpop_regs_type next_r;

  logic        src_now;
  logic        src_prev;
  logic        src_rise;
  logic        clk_rise;
  logic        clk_fall;
  logic        rec_rise;
  logic        ref_rise;
  logic        apb_access;
  logic        apb_done;
  logic        mapped;
  logic [2:0]  events;
  logic [31:0] rd_word;
  logic        sleeping;
  logic        use_rec;
  logic        data_edge;

  // ----------------------------------------
  // Combinational next state
  // ----------------------------------------
  always_comb begin
    next_r = r;
    events = 3'h0;

    // Pins cross into pclk through two flops
    next_r.ref_s1 = reference_clock_in;
    next_r.ref_s2 = r.ref_s1;
    next_r.ref_d  = r.ref_s2;
    next_r.rec_s1 = recovered_clock_in;
    next_r.rec_s2 = r.rec_s1;
    next_r.rec_d  = r.rec_s2;
    next_r.act_s1 = link_activity;
    next_r.act_s2 = r.act_s1;
    next_r.act_d  = r.act_s2;
    next_r.tw_s1  = link_transition;
    next_r.tw_s2  = r.tw_s1;
    next_r.dat_s1 = {link_phase, link_pixel, link_control};
    next_r.dat_s2 = r.dat_s1;

    rec_rise = r.rec_s2 & ~r.rec_d;
    ref_rise = r.ref_s2 & ~r.ref_d;
    sleeping = ~r.ctrl[`DPOP_CTRL_SLEEP_N];
    use_rec  = r.lock_state == st_spread || r.lock_state == st_locked;

    // Word captured on the link clock edge, applied later on the safe edge
    if (rec_rise) begin
      next_r.pend = r.dat_s2;
    end

    // ----------------------------------------
    // Lock sequence
    // ----------------------------------------
    clk_rise = r.clk_out == 1'b0 && next_clk_level(r) == 1'b1;
    unique case (r.lock_state)
      st_off: begin
        next_r.count = 23'h0;
        if (!sleeping) begin
          next_r.lock_state = st_ref_lock;
        end
      end
      st_ref_lock: begin
        // Synced reference rises stand in for the loop's settle time
        if (ref_rise) begin
          if (r.count == 23'(REF_LOCK_CYCLES - 1)) begin
            next_r.count      = 23'h0;
            next_r.lock_state = st_search;
          end else begin
            next_r.count = r.count + 23'h1;
          end
        end
      end
      st_search: begin
        // A transition word needs a live link; a timeout just restarts the hunt
        if (rec_rise && r.tw_s2 && r.act_s2) begin
          next_r.count   = 23'h0;
          next_r.stretch = 1'b1;
          if (HAS_SPREAD) begin
            next_r.lock_state = st_spread;
          end else begin
            next_r.lock_state = st_locked;
            events[`DPOP_INT_LOCK_GAINED] = 1'b1;
          end
        end else if (clk_rise) begin
          if (r.count == 23'(SEARCH_TIMEOUT - 1)) begin
            next_r.count = 23'h0;
            events[`DPOP_INT_SEARCH_TIMEOUT] = 1'b1;
          end else begin
            next_r.count = r.count + 23'h1;
          end
        end
      end
      st_spread: begin
        // Lock is reported only once the spread loop has settled
        if (clk_rise) begin
          if (r.count == 23'(`DPOP_SPREAD_WAIT_CYCLES - 1)) begin
            next_r.count      = 23'h0;
            next_r.lock_state = st_locked;
            events[`DPOP_INT_LOCK_GAINED] = 1'b1;
          end else begin
            next_r.count = r.count + 23'h1;
          end
        end
      end
      st_locked: begin
        next_r.count = 23'h0;
      end
    endcase

    // Silent link drops lock from any post-reference state
    if (!r.act_s2 && use_rec) begin
      next_r.lock_state = st_search;
      next_r.count      = 23'h0;
      next_r.stretch    = 1'b1;
    end
    // Activity loss is news only once the link has been watched
    if (r.act_d && !r.act_s2 && r.lock_state != st_off && r.lock_state != st_ref_lock) begin
      events[`DPOP_INT_ACTIVITY_LOST] = 1'b1;
    end
    if (sleeping) begin
      next_r.lock_state = st_off;
      next_r.count      = 23'h0;
      next_r.stretch    = 1'b0;
    end

    // ----------------------------------------
    // Output clock and stretch
    // ----------------------------------------
    next_r.clk_out = next_clk_level(r);
    // Both sources pass the same two flops, so a switch adds no extra delay
    if (use_rec) begin
      src_now  = r.rec_s2;
      src_prev = r.rec_d;
    end else begin
      src_now  = r.ref_s2;
      src_prev = r.ref_d;
    end
    src_rise = src_now & ~src_prev;
    // Holding high until the new source rises avoids a runt pulse
    if (r.stretch && src_rise) begin
      next_r.stretch = 1'b0;
    end
    clk_fall = r.clk_out & ~next_r.clk_out;
    clk_rise = ~r.clk_out & next_r.clk_out;
    // Data move on the edge the downstream chip does not sample
    data_edge = r.ctrl[`DPOP_CTRL_LATCH_RISING] ? clk_fall : clk_rise;

    // ----------------------------------------
    // Data outputs
    // ----------------------------------------
    if (r.lock_state != st_locked) begin
      next_r.pixel   = 18'h0;
      next_r.control = 9'h0;
      next_r.phase   = 1'b0;
    end else if (data_edge) begin
      next_r.phase = r.pend[27];
      if (r.pend[27]) begin
        next_r.pixel = r.pend[26:9];
      end else begin
        next_r.control = r.pend[8:0];
      end
    end
    next_r.lock_n  = (next_r.lock_state != st_locked);
    next_r.pll_run = (next_r.lock_state != st_off);

    // ----------------------------------------
    // Output enables
    // ----------------------------------------
    // Sync status keeps its driver so a shared bus still sees lock state
    next_r.oe_lock  = !sleeping;
    next_r.oe_data  = !sleeping && r.ctrl[`DPOP_CTRL_DRIVE_EN];
    next_r.oe_clock = !sleeping && r.ctrl[`DPOP_CTRL_DRIVE_EN];

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    apb_access = psel & penable;
    apb_done   = apb_access & r.pready;
    mapped     = paddr == `DPOP_CTRL_OFFSET || paddr == `DPOP_STATUS_OFFSET ||
                 paddr == `DPOP_INT_STATUS_OFFSET || paddr == `DPOP_INT_MASK_OFFSET;
    rd_word = 32'h0;
    unique case (paddr)
      `DPOP_CTRL_OFFSET: begin
        rd_word[5:0] = r.ctrl;
      end
      `DPOP_STATUS_OFFSET: begin
        rd_word[`DPOP_STAT_LOCKED]      = ~r.lock_n;
        rd_word[`DPOP_STAT_SEARCHING]   = r.lock_state == st_search;
        rd_word[`DPOP_STAT_REF_LOCKING] = r.lock_state == st_ref_lock;
        rd_word[`DPOP_STAT_ACTIVITY]    = r.act_s2;
        rd_word[`DPOP_STAT_PLL_RUN]     = r.pll_run;
      end
      `DPOP_INT_STATUS_OFFSET: begin
        rd_word[2:0] = r.int_status;
      end
      `DPOP_INT_MASK_OFFSET: begin
        rd_word[2:0] = r.int_mask;
      end
      default: begin
        rd_word = 32'h0;
      end
    endcase

    // One wait state keeps prdata and pready straight from flops
    next_r.pready  = apb_access & ~r.pready;
    next_r.pslverr = apb_access & ~r.pready & ~mapped;
    if (apb_access && !r.pready) begin
      next_r.prdata = pwrite ? 32'h0 : rd_word;
    end

    // Sticky status: a new event beats a write-one clear
    next_r.int_status = r.int_status;
    if (apb_done && pwrite && paddr == `DPOP_INT_STATUS_OFFSET) begin
      next_r.int_status = r.int_status & ~pwdata[2:0];
    end
    next_r.int_status = next_r.int_status | events;
    // Writes land only in the ready cycle, so a stretched access writes once
    if (apb_done && pwrite && paddr == `DPOP_CTRL_OFFSET) begin
      next_r.ctrl = pwdata[5:0];
    end
    if (apb_done && pwrite && paddr == `DPOP_INT_MASK_OFFSET) begin
      next_r.int_mask = pwdata[2:0];
    end
    next_r.irq = |(next_r.int_status & next_r.int_mask);
  end

  // ----------------------------------------
  // Output clock source
  // ----------------------------------------
  // Parks low while asleep; the pin goes low one cycle after its driver turns off
  function automatic logic next_clk_level(input dpop_regs_type s);
    logic use_rec;
    use_rec = s.lock_state == st_spread || s.lock_state == st_locked;
    if (s.lock_state == st_off) begin
      next_clk_level = 1'b0;
    end else if (s.stretch) begin
      next_clk_level = 1'b1;
    end else if (use_rec) begin
      next_clk_level = s.rec_s2;
    end else begin
      next_clk_level = s.ref_s2;
    end
  endfunction

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r            <= '0;
      r.lock_state <= st_off;
      r.lock_n     <= 1'b1;
      r.ctrl       <= `DPOP_CTRL_RESET;
      r.int_status <= `DPOP_INT_RESET;
      r.int_mask   <= `DPOP_INT_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata             = r.prdata;
  assign pready             = r.pready;
  assign pslverr            = r.pslverr;
  assign irq                = r.irq;
  assign pixel_word_out     = r.pixel;
  assign control_word_out   = r.control;
  assign video_phase_flag   = r.phase;
  assign sync_status_n      = r.lock_n;
  assign parallel_clock_out = r.clk_out;
  assign data_oe            = r.oe_data;
  assign clock_oe           = r.oe_clock;
  assign sync_status_oe     = r.oe_lock;
  assign pll_run            = r.pll_run;
  assign spread_wide        = r.ctrl[`DPOP_CTRL_SPREAD_WIDE];
  assign range_select_hi    = r.ctrl[`DPOP_CTRL_RANGE_HI];
  assign range_select_lo    = r.ctrl[`DPOP_CTRL_RANGE_LO];

endmodule

`default_nettype wire

// *** dv/dpop_sva.sv ***
`timescale 1ns/1ps
`default_nettype none

module dpop_sva (
  input wire logic        pclk,               // System clock
  input wire logic        presetn,            // Async reset, active low
  input wire logic        link_activity,      // Serial input switching
  input wire logic [17:0] pixel_word_out,     // Pixel word pins
  input wire logic [8:0]  control_word_out,   // Control word pins
  input wire logic        video_phase_flag,   // Phase flag pin
  input wire logic        sync_status_n,      // Sync status, low when valid
  input wire logic        parallel_clock_out, // Output clock pin
  input wire logic        data_oe,            // Data pins driven
  input wire logic        clock_oe,           // Clock pin driven
  input wire logic        sync_status_oe,     // Sync pin driven
  input wire logic        pll_run             // PLL running
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------
  // Output rules
  // ----------------------------------------
  property p_gate;
    sync_status_n && $past(sync_status_n) |->
      pixel_word_out == 18'h0 && control_word_out == 9'h0 && !video_phase_flag;
  endproperty
  a_gate: assert property (p_gate)
    else $error("data not forced low while unlocked");
  property p_ctrl;
    $changed(control_word_out) && !sync_status_n && !$past(sync_status_n) |-> !video_phase_flag;
  endproperty
  a_ctrl: assert property (p_ctrl)
    else $error("control word moved in video phase");
  property p_pix;
    !video_phase_flag && !$past(video_phase_flag) && !sync_status_n && !$past(sync_status_n)
      |-> $stable(pixel_word_out);
  endproperty
  a_pix: assert property (p_pix)
    else $error("pixel word moved in control phase");
  property p_edge;
    ($changed(pixel_word_out) || $changed(control_word_out) || $changed(video_phase_flag))
      && !sync_status_n && !$past(sync_status_n) |-> $changed(parallel_clock_out);
  endproperty
  a_edge: assert property (p_edge)
    else $error("data changed away from a clock edge");
  property p_asleep;
    (!pll_run) [*3] |-> !data_oe && !clock_oe && !sync_status_oe && !parallel_clock_out;
  endproperty
  a_asleep: assert property (p_asleep)
    else $error("pins driven while asleep");
  property p_split;
    data_oe && $past(data_oe) |-> clock_oe && sync_status_oe;
  endproperty
  a_split: assert property (p_split)
    else $error("enables disagree");
  property p_loss;
    (!link_activity) [*8] |-> sync_status_n;
  endproperty
  a_loss: assert property (p_loss)
    else $error("still locked without link activity");
  property p_fell;
    $fell(sync_status_n) |-> pll_run && sync_status_oe;
  endproperty
  a_fell: assert property (p_fell)
    else $error("lock reported while asleep");
endmodule

`default_nettype wire

// *** dv/dpop_video_sink.sv ***
`timescale 1ns/1ps
`default_nettype none

module dpop_video_sink (
  input  wire logic        clk_in,       // Output clock pin
  input  wire logic        latch_rising, // Latch on rising edge
  input  wire logic        valid_n,      // Sync status pin
  input  wire logic        drive,        // Data pins driven
  input  wire logic [17:0] pixel,        // Pixel pins
  input  wire logic [8:0]  control,      // Control pins
  input  wire logic        phase,        // Phase flag pin
  output logic      [17:0] seen_pixel,   // Last latched pixel word
  output logic      [8:0]  seen_control, // Last latched control word
  output logic             seen_phase    // Last latched phase
);
  // Floating pins or invalid data are never taken
  always @(clk_in) begin
    if (clk_in === latch_rising && valid_n === 1'b0 && drive === 1'b1) begin
      seen_phase = phase;
      if (phase) seen_pixel = pixel;
      else seen_control = control;
    end
  end
endmodule

`default_nettype wire

// *** dv/test_dpop_output_port.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dpop_params.svh"

module test_dpop_output_port;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        ref_clk = 1'b0, rec_clk = 1'b0, link_run = 1'b0, lr = 1'b1;
  logic        act = 1'b0, trans = 1'b0, ph = 1'b0;
  logic [17:0] lpix = 18'h0, pix_o, s_pix;
  logic [8:0]  lctl = 9'h0, ctl_o, s_ctl, last_c = 9'h0;
  logic        pready, pslverr, irq, phase_o, sync_n, pclk_o, data_oe, clock_oe, sync_oe;
  logic        pll_run, spread, rng_hi, rng_lo, s_ph;
  int          failures = 0, n_tests = 0, cyc = 0;

  always #2 pclk = ~pclk;
  always #81 ref_clk = ~ref_clk; // Within 2 percent of the link rate
  // Link clock stands still outside frames
  always #80 if (link_run) rec_clk = ~rec_clk;
  always @(posedge pclk) cyc++;

  dpop_output_port #(.REF_LOCK_CYCLES(8), .SEARCH_TIMEOUT(64), .HAS_SPREAD(1'b1)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .reference_clock_in(ref_clk), .recovered_clock_in(rec_clk),
    .link_activity(act), .link_transition(trans), .link_phase(ph), .link_pixel(lpix),
    .link_control(lctl), .pixel_word_out(pix_o), .control_word_out(ctl_o),
    .video_phase_flag(phase_o), .sync_status_n(sync_n), .parallel_clock_out(pclk_o),
    .data_oe(data_oe), .clock_oe(clock_oe), .sync_status_oe(sync_oe), .pll_run(pll_run),
    .spread_wide(spread), .range_select_hi(rng_hi), .range_select_lo(rng_lo));

  dpop_video_sink sink (.clk_in(pclk_o), .latch_rising(lr), .valid_n(sync_n),
    .drive(data_oe), .pixel(pix_o), .control(ctl_o), .phase(phase_o),
    .seen_pixel(s_pix), .seen_control(s_ctl), .seen_phase(s_ph));

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, x, s);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
    repeat (3) @(posedge pclk);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask

  task automatic send(input logic p, input logic [17:0] px, input logic [8:0] c);
    @(negedge rec_clk);
    @(posedge pclk);
    ph <= p;
    lpix <= px;
    lctl <= c;
    repeat (4) @(negedge rec_clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [31:0] q;
    logic        e;
    rd(`DPOP_CTRL_OFFSET, q);
    chk("ctrl reset", q, 32'h10);
    rd(`DPOP_INT_STATUS_OFFSET, q);
    chk("int reset", q, 32'h0);
    apb(1'b0, 12'h010, 32'h0, q, e);
    chk("unmapped err", e, 1'b1);
    chk("unmapped data", q, 32'h0);
    chk("asleep", {pll_run, data_oe, clock_oe, sync_oe, sync_n}, 5'h1);
    $display("test reset done");
  endtask

  task automatic t_lock;
    logic [31:0] q;
    int          n;
    act <= 1'b1;
    trans <= 1'b1;
    link_run = 1'b1;
    wr(`DPOP_INT_MASK_OFFSET, 32'h1);
    wr(`DPOP_CTRL_OFFSET, 32'h35); // Link at 6.25 MHz sits in the 5 to 10 MHz band
    chk("range spread", {rng_hi, rng_lo, spread}, 3'h2);
    n = 0;
    while (sync_n !== 1'b0 && n < 30000) begin
      @(posedge pclk);
      n++;
    end
    chk("locked", sync_n, 1'b0);
    rd(`DPOP_STATUS_OFFSET, q);
    chk("status locked", q, 32'h19);
    @(negedge rec_clk);
    @(posedge pclk);
    trans <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("irq lock", irq, 1'b1);
    rd(`DPOP_INT_STATUS_OFFSET, q);
    chk("lock event", q[0], 1'b1);
    wr(`DPOP_INT_STATUS_OFFSET, 32'h1);
    wr(`DPOP_INT_MASK_OFFSET, 32'h4);
    chk("irq cleared", irq, 1'b0);
    $display("test lock done");
  endtask

  task automatic t_words(input logic l, input logic [17:0] p, input logic [8:0] c);
    wr(`DPOP_CTRL_OFFSET, {26'h0, 5'h1a, l});
    lr = l;
    send(1'b1, p, ~c);
    chk("pixel", s_pix, p);
    chk("phase high", s_ph, 1'b1);
    chk("control held", ctl_o, last_c);
    send(1'b0, ~p, c);
    chk("control", s_ctl, c);
    chk("phase low", s_ph, 1'b0);
    chk("pixel held", pix_o, p);
    last_c = c;
    $display("test words done");
  endtask

  task automatic t_drive;
    wr(`DPOP_CTRL_OFFSET, 32'h25);
    chk("drive off", {data_oe, clock_oe, sync_oe, sync_n}, 4'h2);
    wr(`DPOP_CTRL_OFFSET, 32'h35);
    $display("test drive done");
  endtask

  task automatic t_loss;
    logic [31:0] q;
    logic        prev;
    int          n, t0;
    t0 = cyc;
    act <= 1'b0;
    link_run = 1'b0;
    n = 0;
    while (sync_n !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk("unlocked", sync_n, 1'b1);
    @(posedge pclk);
    chk("zeroed", {pix_o, ctl_o, phase_o}, 28'h0);
    repeat (3) @(posedge pclk);
    chk("irq loss", irq, 1'b1);
    n = 0;
    prev = pclk_o;
    repeat (200) begin
      @(posedge pclk);
      if (pclk_o !== prev) n++;
      prev = pclk_o;
    end
    chk("ref out", n >= 8, 1'b1);
    n = 0;
    do begin
      rd(`DPOP_INT_STATUS_OFFSET, q);
      n++;
    end while (q[1] !== 1'b1 && n < 1500);
    chk("timeout", q[1], 1'b1);
    chk("timeout span", (cyc - t0) inside {[2300:2900]}, 1'b1);
    chk("searching", sync_n, 1'b1);
    rd(`DPOP_STATUS_OFFSET, q);
    chk("status search", q, 32'h12);
    $display("test loss done");
  endtask

  task automatic t_sleep;
    wr(`DPOP_CTRL_OFFSET, 32'h12);
    chk("sleep", {pll_run, data_oe, clock_oe, sync_oe, pclk_o}, 5'h0);
    chk("spread wide", spread, 1'b1);
    $display("test sleep done");
  endtask

  task automatic tally_and_finish;
    $display("TB: %0d checks, %0d mismatches", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_lock;
    t_words(1'b1, 18'h2a5a5, 9'h155);
    t_words(1'b0, 18'h3ffff, 9'h1ff);
    t_words(1'b1, 18'h00001, 9'h001);
    t_drive;
    t_loss;
    t_sleep;
    tally_and_finish;
  end

  initial begin
    repeat (80000) @(posedge pclk);
    failures++;
    tally_and_finish;
  end
endmodule

bind dpop_output_port dpop_sva u_sva (.pclk(pclk), .presetn(presetn),
  .link_activity(link_activity), .pixel_word_out(pixel_word_out),
  .control_word_out(control_word_out), .video_phase_flag(video_phase_flag),
  .sync_status_n(sync_status_n), .parallel_clock_out(parallel_clock_out),
  .data_oe(data_oe), .clock_oe(clock_oe), .sync_status_oe(sync_status_oe),
  .pll_run(pll_run));

`default_nettype wire
